// [hdl/dtc_params.svh]
// Constants for the dual timer/counter block
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define DTC_ADDR_CONTROL   8'h88
`define DTC_ADDR_MODE      8'h89
`define DTC_ADDR_U0_LOW    8'h8a
`define DTC_ADDR_U1_LOW    8'h8b
`define DTC_ADDR_U0_HIGH   8'h8c
`define DTC_ADDR_U1_HIGH   8'h8d

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define DTC_CONTROL_RST    8'h00
`define DTC_MODE_RST       8'h00
`define DTC_BYTE_RST       8'h00
`define DTC_READ_IDLE      8'h00

// ---------------------------------------------------------------
// timer_mode field positions
// ---------------------------------------------------------------
`define DTC_U1_GATE_BIT    7
`define DTC_U1_CT_BIT      6
`define DTC_U1_MODE_HI     5
`define DTC_U1_MODE_LO     4
`define DTC_U0_GATE_BIT    3
`define DTC_U0_CT_BIT      2
`define DTC_U0_MODE_HI     1
`define DTC_U0_MODE_LO     0

// ---------------------------------------------------------------
// timer_control field positions
// ---------------------------------------------------------------
`define DTC_U1_OVF_BIT     7
`define DTC_U1_RUN_BIT     6
`define DTC_U0_OVF_BIT     5
`define DTC_U0_RUN_BIT     4
`define DTC_IRQ1_FLAG_BIT  3
`define DTC_IRQ1_TYPE_BIT  2
`define DTC_IRQ0_FLAG_BIT  1
`define DTC_IRQ0_TYPE_BIT  0

// ---------------------------------------------------------------
// Mode codes
// ---------------------------------------------------------------
`define DTC_MODE_13BIT     2'h0
`define DTC_MODE_16BIT     2'h1
`define DTC_MODE_RELOAD    2'h2
`define DTC_MODE_SPLIT     2'h3

// ---------------------------------------------------------------
// Machine cycle timing
// ---------------------------------------------------------------
`define DTC_MC_LAST        4'hb
`define DTC_PHASE_RST      4'h0
`define DTC_PHASE_ONE      4'h1
`define DTC_SAMPLE_PHASE   4'h9
`define DTC_UPDATE_PHASE   4'h4

// ---------------------------------------------------------------
// Counting constants
// ---------------------------------------------------------------
`define DTC_PRESCALE_MSB   4
`define DTC_PRESCALE_ALL   5'h1f
`define DTC_BYTE_ALL       8'hff
`define DTC_BYTE_ONE       8'h01

`endif

// [hdl/dtc_pkg.sv]
// Types shared by the dual timer/counter block
package dtc_pkg;

    // One unit's count after a step, plus rollover
    typedef struct packed {
        logic       ovf;
        logic [7:0] high;
        logic [7:0] low;
    } dtc_count_t;

    // Interrupt sources in core priority order
    typedef struct packed {
        logic unit1_ovf;
        logic ext_irq1;
        logic unit0_ovf;
        logic ext_irq0;
    } dtc_irq_t;

endpackage

// [hdl/dtc_pin_sampler.sv]
// Pin synchroniser and per-machine-cycle fall sampler
`timescale 1ns/1ps
`include "dtc_params.svh"

module dtc_pin_sampler
    import dtc_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic pin_i,
    input  wire logic sample_i,
    input  wire logic update_i,
    output logic      level_o,
    output logic      sample_o,
    output logic      fall_o
);

    logic sync1_reg;
    logic sync2_reg;
    logic samp_reg;
    logic pend_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
        end
    end

    // Idle-high reset so release does not fake an edge
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            samp_reg <= 1'b1;
        end else if (sample_i) begin
            samp_reg <= sync2_reg;
        end
    end

    // High then low sample; reported at next update phase
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pend_reg <= 1'b0;
        end else if (sample_i && samp_reg && !sync2_reg) begin
            pend_reg <= 1'b1;
        end else if (update_i) begin
            pend_reg <= 1'b0;
        end
    end

    assign level_o  = sync2_reg;
    assign sample_o = samp_reg;
    assign fall_o   = update_i & pend_reg;

endmodule

// [hdl/dtc_timer_counter.sv]
// Dual 16-bit timer/counter with external interrupt flags
//
// Overview of operation
// - Timer function increments once per 12-clock machine cycle.
// - Counter function counts high-then-low count pin samples.
// - Counted edge visible the machine cycle after its detection.
// - Gate bit set: count only while run bit and interrupt pin high.
// - Counter-select bit set picks pin edges, clear picks machine cycles.
// - Two-bit mode field per unit in timer_mode, upper bit is MSB.
// - Mode 0: high byte counts through 5-bit prescaler in low byte.
// - Mode 1: low and high bytes cascade into 16-bit counter.
// - Mode 2: low byte counts, reloads from high byte on overflow.
// - Unit 1 in mode 3 holds its count.
// - Unit 0 mode 3: two 8-bit counters, high uses unit 1 run bit and flag.
// - Overflow flag set on rollover, cleared on interrupt vectoring.
// - Run bits switch each unit on and off.
// - External interrupt flags set by falling edge or low level.
// - Trigger-type bit set selects edge, clear selects level detection.
// - Vectoring clears edge flags only; level flags follow the pin.
// - Overflow means rolling from all ones to zero, or to the reload value in mode 2.
// - Run bit does not clear counts; prescaler upper bits untouched.
`timescale 1ns/1ps
`include "dtc_params.svh"

module dtc_timer_counter
    import dtc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_wdata_i,
    input  wire logic       sfr_rd_i,
    output logic      [7:0] sfr_rdata_o,
    output logic            sfr_hit_o,
    input  wire logic       unit0_count_pin_i,
    input  wire logic       unit1_count_pin_i,
    input  wire logic       ext_irq0_pin_i,
    input  wire logic       ext_irq1_pin_i,
    output dtc_irq_t        irq_req_o,
    input  dtc_irq_t        irq_ack_i,
    output logic            unit1_ovf_o
);

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [7:0] timer_control_reg;
    logic [7:0] timer_mode_reg;
    logic [7:0] unit0_low_reg;
    logic [7:0] unit0_high_reg;
    logic [7:0] unit1_low_reg;
    logic [7:0] unit1_high_reg;
    logic [3:0] phase_reg;
    logic [7:0] rdata_reg;
    logic       hit_reg;
    logic       u1_ovf_reg;

    logic sample_phase;
    logic update_phase;

    logic fall_t0;
    logic fall_t1;
    logic lvl_i0, smp_i0, fall_i0;
    logic lvl_i1, smp_i1, fall_i1;

    // ---------------------------------------------------------------
    // Machine cycle divider
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            phase_reg <= `DTC_PHASE_RST;
        end else if (phase_reg == `DTC_MC_LAST) begin
            phase_reg <= `DTC_PHASE_RST;
        end else begin
            phase_reg <= phase_reg + `DTC_PHASE_ONE;
        end
    end

    assign sample_phase = (phase_reg == `DTC_SAMPLE_PHASE);
    assign update_phase = (phase_reg == `DTC_UPDATE_PHASE);

    // ---------------------------------------------------------------
    // Pin samplers
    // ---------------------------------------------------------------
    // Levels under a machine cycle may be missed
    dtc_pin_sampler u_smp_t0 (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .pin_i    (unit0_count_pin_i),
        .sample_i (sample_phase),
        .update_i (update_phase),
        .level_o  (),
        .sample_o (),
        .fall_o   (fall_t0)
    );

    dtc_pin_sampler u_smp_t1 (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .pin_i    (unit1_count_pin_i),
        .sample_i (sample_phase),
        .update_i (update_phase),
        .level_o  (),
        .sample_o (),
        .fall_o   (fall_t1)
    );

    dtc_pin_sampler u_smp_i0 (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .pin_i    (ext_irq0_pin_i),
        .sample_i (sample_phase),
        .update_i (update_phase),
        .level_o  (lvl_i0),
        .sample_o (smp_i0),
        .fall_o   (fall_i0)
    );

    dtc_pin_sampler u_smp_i1 (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .pin_i    (ext_irq1_pin_i),
        .sample_i (sample_phase),
        .update_i (update_phase),
        .level_o  (lvl_i1),
        .sample_o (smp_i1),
        .fall_o   (fall_i1)
    );

    // ---------------------------------------------------------------
    // Field decode
    // ---------------------------------------------------------------
    logic [1:0] u0_mode;
    logic [1:0] u1_mode;
    logic       u0_run;
    logic       u1_run;
    logic       u0_en;
    logic       u1_en;
    logic       u0_inc;
    logic       u1_inc;
    logic       u0_split;

    assign u0_mode = {timer_mode_reg[`DTC_U0_MODE_HI],
                      timer_mode_reg[`DTC_U0_MODE_LO]};
    assign u1_mode = {timer_mode_reg[`DTC_U1_MODE_HI],
                      timer_mode_reg[`DTC_U1_MODE_LO]};
    assign u0_run  = timer_control_reg[`DTC_U0_RUN_BIT];
    assign u1_run  = timer_control_reg[`DTC_U1_RUN_BIT];
    assign u0_split = (u0_mode == `DTC_MODE_SPLIT);

    assign u0_en = u0_run &
                   (!timer_mode_reg[`DTC_U0_GATE_BIT] | lvl_i0);
    assign u1_en = u1_run &
                   (!timer_mode_reg[`DTC_U1_GATE_BIT] | lvl_i1);

    assign u0_inc = u0_en & (timer_mode_reg[`DTC_U0_CT_BIT] ?
                             fall_t0 : update_phase);
    assign u1_inc = u1_en & (timer_mode_reg[`DTC_U1_CT_BIT] ?
                             fall_t1 : update_phase);

    // ---------------------------------------------------------------
    // Count step for one unit
    // ---------------------------------------------------------------
    function automatic dtc_count_t count_step(
        input logic [1:0] mode,
        input logic       inc,
        input logic [7:0] high,
        input logic [7:0] low
    );
        dtc_count_t r;
        r.ovf  = 1'b0;
        r.high = high;
        r.low  = low;
        if (inc) begin
            case (mode)
                `DTC_MODE_13BIT: begin
                    // Bits 7:5 left as they are
                    r.low[`DTC_PRESCALE_MSB:0] =
                        low[`DTC_PRESCALE_MSB:0] + 5'h01;
                    if (low[`DTC_PRESCALE_MSB:0] == `DTC_PRESCALE_ALL) begin
                        r.high = high + `DTC_BYTE_ONE;
                        r.ovf  = (high == `DTC_BYTE_ALL);
                    end
                end
                `DTC_MODE_16BIT: begin
                    r.low = low + `DTC_BYTE_ONE;
                    if (low == `DTC_BYTE_ALL) begin
                        r.high = high + `DTC_BYTE_ONE;
                        r.ovf  = (high == `DTC_BYTE_ALL);
                    end
                end
                `DTC_MODE_RELOAD: begin
                    if (low == `DTC_BYTE_ALL) begin
                        r.low = high;
                        r.ovf = 1'b1;
                    end else begin
                        r.low = low + `DTC_BYTE_ONE;
                    end
                end
                default: begin
                    // Split: low byte only
                    r.low = low + `DTC_BYTE_ONE;
                    r.ovf = (low == `DTC_BYTE_ALL);
                end
            endcase
        end
        return r;
    endfunction

    dtc_count_t u0_step;
    dtc_count_t u1_step;
    logic [7:0] u0_high_split;
    logic       u0_high_ovf;
    logic       u1_hold;

    assign u0_step = count_step(u0_mode, u0_inc,
                                unit0_high_reg, unit0_low_reg);
    assign u1_hold = (u1_mode == `DTC_MODE_SPLIT);
    assign u1_step = count_step(u1_mode, u1_inc & !u1_hold,
                                unit1_high_reg, unit1_low_reg);

    // Unit 0 high byte in split: machine cycles, unit 1 run bit
    assign u0_high_ovf   = u0_split & u1_run & update_phase &
                           (unit0_high_reg == `DTC_BYTE_ALL);
    assign u0_high_split = (u0_split & u1_run & update_phase) ?
                           unit0_high_reg + `DTC_BYTE_ONE :
                           unit0_high_reg;

    logic u0_ovf_evt;
    logic u1_ovf_evt;

    assign u0_ovf_evt = u0_step.ovf;
    // Unit 1 loses its flag in split mode
    assign u1_ovf_evt = u0_split ? u0_high_ovf : u1_step.ovf;

    // ---------------------------------------------------------------
    // Bus write decode
    // ---------------------------------------------------------------
    logic wr_ctl;
    logic wr_mode;
    logic wr_u0l;
    logic wr_u0h;
    logic wr_u1l;
    logic wr_u1h;

    always_comb begin
        wr_ctl  = 1'b0;
        wr_mode = 1'b0;
        wr_u0l  = 1'b0;
        wr_u0h  = 1'b0;
        wr_u1l  = 1'b0;
        wr_u1h  = 1'b0;
        if (!sfr_wr_i) begin
            wr_ctl = 1'b0;
        end else if (sfr_addr_i == `DTC_ADDR_CONTROL) begin
            wr_ctl = 1'b1;
        end else if (sfr_addr_i == `DTC_ADDR_MODE) begin
            wr_mode = 1'b1;
        end else if (sfr_addr_i == `DTC_ADDR_U0_LOW) begin
            wr_u0l = 1'b1;
        end else if (sfr_addr_i == `DTC_ADDR_U0_HIGH) begin
            wr_u0h = 1'b1;
        end else if (sfr_addr_i == `DTC_ADDR_U1_LOW) begin
            wr_u1l = 1'b1;
        end else if (sfr_addr_i == `DTC_ADDR_U1_HIGH) begin
            wr_u1h = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Mode register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            timer_mode_reg <= `DTC_MODE_RST;
        end else if (wr_mode) begin
            timer_mode_reg <= sfr_wdata_i;
        end
    end

    // ---------------------------------------------------------------
    // Count bytes; software write wins over count
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            unit0_low_reg  <= `DTC_BYTE_RST;
            unit0_high_reg <= `DTC_BYTE_RST;
        end else begin
            unit0_low_reg  <= wr_u0l ? sfr_wdata_i : u0_step.low;
            if (wr_u0h) begin
                unit0_high_reg <= sfr_wdata_i;
            end else if (u0_split) begin
                unit0_high_reg <= u0_high_split;
            end else begin
                unit0_high_reg <= u0_step.high;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            unit1_low_reg  <= `DTC_BYTE_RST;
            unit1_high_reg <= `DTC_BYTE_RST;
        end else begin
            unit1_low_reg  <= wr_u1l ? sfr_wdata_i : u1_step.low;
            unit1_high_reg <= wr_u1h ? sfr_wdata_i : u1_step.high;
        end
    end

    // ---------------------------------------------------------------
    // Control register; hardware sets win
    // ---------------------------------------------------------------
    logic [7:0] ctl_next;

    always_comb begin
        ctl_next = wr_ctl ? sfr_wdata_i : timer_control_reg;
        // Overflow flags
        if (irq_ack_i.unit0_ovf) begin
            ctl_next[`DTC_U0_OVF_BIT] = 1'b0;
        end
        if (u0_ovf_evt) begin
            ctl_next[`DTC_U0_OVF_BIT] = 1'b1;
        end
        if (irq_ack_i.unit1_ovf) begin
            ctl_next[`DTC_U1_OVF_BIT] = 1'b0;
        end
        if (u1_ovf_evt) begin
            ctl_next[`DTC_U1_OVF_BIT] = 1'b1;
        end
        // External interrupt 0
        if (timer_control_reg[`DTC_IRQ0_TYPE_BIT]) begin
            if (irq_ack_i.ext_irq0) begin
                ctl_next[`DTC_IRQ0_FLAG_BIT] = 1'b0;
            end
            if (fall_i0) begin
                ctl_next[`DTC_IRQ0_FLAG_BIT] = 1'b1;
            end
        end else begin
            ctl_next[`DTC_IRQ0_FLAG_BIT] = !smp_i0;
        end
        // External interrupt 1
        if (timer_control_reg[`DTC_IRQ1_TYPE_BIT]) begin
            if (irq_ack_i.ext_irq1) begin
                ctl_next[`DTC_IRQ1_FLAG_BIT] = 1'b0;
            end
            if (fall_i1) begin
                ctl_next[`DTC_IRQ1_FLAG_BIT] = 1'b1;
            end
        end else begin
            ctl_next[`DTC_IRQ1_FLAG_BIT] = !smp_i1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            timer_control_reg <= `DTC_CONTROL_RST;
        end else begin
            timer_control_reg <= ctl_next;
        end
    end

    // ---------------------------------------------------------------
    // Read port, one cycle latency
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_reg <= `DTC_READ_IDLE;
            hit_reg   <= 1'b0;
        end else if (!sfr_rd_i) begin
            hit_reg   <= 1'b0;
        end else if (sfr_addr_i == `DTC_ADDR_CONTROL) begin
            rdata_reg <= timer_control_reg;
            hit_reg   <= 1'b1;
        end else if (sfr_addr_i == `DTC_ADDR_MODE) begin
            rdata_reg <= timer_mode_reg;
            hit_reg   <= 1'b1;
        end else if (sfr_addr_i == `DTC_ADDR_U0_LOW) begin
            rdata_reg <= unit0_low_reg;
            hit_reg   <= 1'b1;
        end else if (sfr_addr_i == `DTC_ADDR_U0_HIGH) begin
            rdata_reg <= unit0_high_reg;
            hit_reg   <= 1'b1;
        end else if (sfr_addr_i == `DTC_ADDR_U1_LOW) begin
            rdata_reg <= unit1_low_reg;
            hit_reg   <= 1'b1;
        end else if (sfr_addr_i == `DTC_ADDR_U1_HIGH) begin
            rdata_reg <= unit1_high_reg;
            hit_reg   <= 1'b1;
        end else begin
            rdata_reg <= `DTC_READ_IDLE;
            hit_reg   <= 1'b0;
        end
    end

    // Unit 1 rollover pulse, live in split mode too
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            u1_ovf_reg <= 1'b0;
        end else begin
            u1_ovf_reg <= u1_step.ovf;
        end
    end

    assign sfr_rdata_o = rdata_reg;
    assign sfr_hit_o   = hit_reg;
    assign unit1_ovf_o = u1_ovf_reg;

    assign irq_req_o.unit0_ovf = timer_control_reg[`DTC_U0_OVF_BIT];
    assign irq_req_o.unit1_ovf = timer_control_reg[`DTC_U1_OVF_BIT];
    assign irq_req_o.ext_irq0  = timer_control_reg[`DTC_IRQ0_FLAG_BIT];
    assign irq_req_o.ext_irq1  = timer_control_reg[`DTC_IRQ1_FLAG_BIT];

endmodule

// [tb/dtc_chk.sv]
// Port checker for the dual timer/counter
`timescale 1ns/1ps
module dtc_chk
    import dtc_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic       sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic       sfr_rd_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic       sfr_hit_o,
    input wire logic       unit0_count_pin_i,
    input wire logic       unit1_count_pin_i,
    input wire logic       ext_irq0_pin_i,
    input wire logic       ext_irq1_pin_i,
    input wire dtc_irq_t   irq_req_o,
    input wire dtc_irq_t   irq_ack_i,
    input wire logic       unit1_ovf_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic       edge0_reg;
    logic [4:0] low0_reg;
    wire        map_w = sfr_addr_i inside {[8'h88:8'h8d]};
    // ------------------------------------------------------
    // Helpers
    // ------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            edge0_reg <= 1'b0;
        end else if (sfr_wr_i && sfr_addr_i == 8'h88) begin
            edge0_reg <= sfr_wdata_i[0];
        end
    end
    // Saturates at all ones
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || ext_irq0_pin_i) begin
            low0_reg <= 5'h00;
        end else if (low0_reg != 5'h1f) begin
            low0_reg <= low0_reg + 5'h01;
        end
    end
    // ------------------------------------------------------
    // Assertions
    // ------------------------------------------------------
    a_hit_mapped: assert property (sfr_rd_i && map_w |=> sfr_hit_o)
        else $error("mapped read gave no hit");
    a_read_unmapped: assert property (sfr_rd_i && !map_w |=>
        !sfr_hit_o && sfr_rdata_o == 8'h00) else $error("unmapped read");
    a_mode_readback: assert property (sfr_wr_i && sfr_addr_i == 8'h89
        ##2 sfr_rd_i && !sfr_wr_i && sfr_addr_i == 8'h89
        |=> sfr_rdata_o == $past(sfr_wdata_i, 3)) else $error("mode readback");
    a_rdata_hold: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
        else $error("read data moved without read");
    a_ovf_spacing: assert property ($rose(unit1_ovf_o) |=> !unit1_ovf_o [*8])
        else $error("overflow pulses too close");
    a_ovf_flag: assert property (unit1_ovf_o |-> ##[0:2] irq_req_o.unit1_ovf)
        else $error("overflow without flag");
    a_ack_clear: assert property (irq_ack_i.unit0_ovf |->
        ##[1:2] !irq_req_o.unit0_ovf) else $error("ack left flag set");
    a_level_set: assert property (!edge0_reg && low0_reg == 5'h14
        |-> irq_req_o.ext_irq0) else $error("low level not flagged");
    a_level_drop: assert property (!edge0_reg && $rose(ext_irq0_pin_i)
        |-> ##[2:20] !irq_req_o.ext_irq0) else $error("level flag stuck");
    c_ovf: cover property (unit1_ovf_o);
    c_flag0: cover property (irq_req_o.unit0_ovf);
    c_unmapped: cover property (sfr_rd_i && !map_w);
endmodule

bind dtc_timer_counter dtc_chk u_chk (.clk_i, .rst_n_i, .sfr_addr_i,
    .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i, .sfr_rdata_o, .sfr_hit_o,
    .unit0_count_pin_i, .unit1_count_pin_i, .ext_irq0_pin_i,
    .ext_irq1_pin_i, .irq_req_o, .irq_ack_i, .unit1_ovf_o);

// [tb/dtc_pin_model.sv]
// Count pin source, levels held a machine cycle or more
`timescale 1ns/1ps
module dtc_pin_model (
    input  wire logic       clk_i,
    input  wire logic [3:0] num_i,
    input  wire logic       go_i,
    output logic            busy_o,
    output logic            pin_o
);
    integer seed;
    initial begin
        seed = 35220;
        busy_o = 1'b0;
        pin_o = 1'b1;
        forever begin
            @(posedge clk_i);
            if (go_i) begin
                busy_o <= 1'b1;
                repeat (num_i) begin
                    pin_o <= 1'b0;
                    repeat (13 + {$random(seed)} % 8) @(posedge clk_i);
                    pin_o <= 1'b1;
                    repeat (13 + {$random(seed)} % 8) @(posedge clk_i);
                end
                busy_o <= 1'b0;
            end
        end
    end
endmodule

// [tb/test_dtc_timer_counter.sv]
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
module test_dtc_timer_counter
    import dtc_pkg::*;
;
    logic       clk_i = 1'b0, rst_n_i, sfr_wr_i, sfr_rd_i, sfr_hit_o, unit1_ovf_o;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, h, l, c, msk;
    logic [1:0] irq_pin, go;
    wire  [1:0] cnt_pin, busy;
    logic [3:0] num;
    logic [16:0] e;
    dtc_irq_t   irq_req_o, irq_ack_i;
    integer     seed = 35220, num_errors = 0, tests_run = 0, cycles = 0;
    integer     u, m, n, k;
    always #2.5 clk_i = ~clk_i;
    dtc_timer_counter dut (.clk_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i,
        .sfr_wdata_i, .sfr_rd_i, .sfr_rdata_o, .sfr_hit_o,
        .unit0_count_pin_i(cnt_pin[0]), .unit1_count_pin_i(cnt_pin[1]),
        .ext_irq0_pin_i(irq_pin[0]), .ext_irq1_pin_i(irq_pin[1]),
        .irq_req_o, .irq_ack_i, .unit1_ovf_o);
    dtc_pin_model pm0 (.clk_i, .num_i(num), .go_i(go[0]),
        .busy_o(busy[0]), .pin_o(cnt_pin[0]));
    dtc_pin_model pm1 (.clk_i, .num_i(num), .go_i(go[1]),
        .busy_o(busy[1]), .pin_o(cnt_pin[1]));
    // ------------------------------------------------------
    // Tasks and expectation
    // ------------------------------------------------------
    task test_done;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            test_done;
        end
    end
    // Strobes drop a cycle between calls
    task wr(input logic [7:0] a, d);
        sfr_addr_i <= a; sfr_wdata_i <= d; sfr_wr_i <= 1'b1;
        @(posedge clk_i); sfr_wr_i <= 1'b0; @(posedge clk_i);
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        sfr_addr_i <= a; sfr_rd_i <= 1'b1;
        @(posedge clk_i); sfr_rd_i <= 1'b0; @(posedge clk_i);
        d = sfr_rdata_o;
    endtask
    task ack(input logic [3:0] a);
        irq_ack_i <= a; @(posedge clk_i); irq_ack_i <= 4'h0;
        repeat (3) @(posedge clk_i);
    endtask
    function automatic logic [16:0] nxt(input int u, m, k, logic [7:0] h, l);
        logic o;
        o = 1'b0;
        repeat (k) begin
            case (m)
                0: begin if (l[4:0] == 5'h1f) begin h++; o |= (h == 8'h00); end l[4:0]++; end
                1: begin l++; if (l == 8'h00) begin h++; o |= (h == 8'h00); end end
                2: begin if (l == 8'hff) begin l = h; o = 1'b1; end else l++; end
                default: if (u == 0) begin l++; o |= (l == 8'h00); end
            endcase
        end
        return {o, h, l};
    endfunction
    // ------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------
    initial begin
        rst_n_i = 1'b0; sfr_wr_i = 1'b0; sfr_rd_i = 1'b0; sfr_addr_i = 8'h00;
        sfr_wdata_i = 8'h00; irq_pin = 2'b11; irq_ack_i = 4'h0; go = 2'b00; num = 4'h0;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rd(8'h88, c); `CHK(c, 8'h00)
        rd(8'h89, c); `CHK(c, 8'h00)
        rd(8'h90, c); `CHK(c, 8'h00)
        repeat (4) begin
            h = $random(seed); wr(8'h89, h); rd(8'h89, c); `CHK(c, h)
        end
        // Gate open 12k clocks; its fall flags an edge
        wr(8'h88, 8'h05); irq_pin <= 2'b00; repeat (40) @(posedge clk_i);
        for (u = 0; u < 2; u++) for (m = 0; m < 4; m++) for (n = 0; n < 2; n++) begin
            h = (n && m != 2) ? 8'hff : $random(seed);
            l = n ? 8'hff : $random(seed);
            k = 1 + {$random(seed)} % 3;
            msk = (m == 0) ? 8'h1f : 8'hff;
            wr(8'h8a + 8'(u), l); wr(8'h8c + 8'(u), h);
            wr(8'h89, 8'(m + 8) << (4 * u));
            wr(8'h88, u ? 8'h45 : 8'h15);
            irq_pin[u] <= 1'b1; repeat (12 * k) @(posedge clk_i);
            irq_pin[u] <= 1'b0; repeat (40) @(posedge clk_i);
            e = nxt(u, m, k, h, l);
            rd(8'h8a + 8'(u), c); `CHK(c & msk, e[7:0] & msk)
            rd(8'h8c + 8'(u), c); `CHK(c, e[15:8])
            rd(8'h88, c); `CHK(c, (u ? 8'h4d : 8'h17) | 8'(e[16]) << (5 + 2 * u))
            ack(4'hf); `CHK(irq_req_o, 4'h0)
        end
        // Edge counting on the count pins
        for (u = 0; u < 2; u++) begin
            h = $random(seed); l = $random(seed); num <= 4'(1 + {$random(seed)} % 10);
            wr(8'h8a + 8'(u), l); wr(8'h8c + 8'(u), h);
            wr(8'h89, 8'h05 << (4 * u)); wr(8'h88, u ? 8'h45 : 8'h15);
            go[u] <= 1'b1; @(posedge clk_i); go[u] <= 1'b0; repeat (2) @(posedge clk_i);
            while (busy[u]) @(posedge clk_i);
            repeat (40) @(posedge clk_i); wr(8'h88, 8'h05);
            e = nxt(u, 1, num, h, l);
            rd(8'h8a + 8'(u), c); `CHK(c, e[7:0])
            rd(8'h8c + 8'(u), c); `CHK(c, e[15:8])
        end
        // Level flags follow pins, ignore ack
        irq_pin <= 2'b11; wr(8'h88, 8'h00); repeat (40) @(posedge clk_i);
        for (u = 0; u < 2; u++) begin
            irq_pin[u] <= 1'b0; repeat (40) @(posedge clk_i);
            `CHK(irq_req_o[2 * u], 1'b1)
            ack(4'hf); `CHK(irq_req_o[2 * u], 1'b1)
            irq_pin[u] <= 1'b1; repeat (40) @(posedge clk_i);
            `CHK(irq_req_o[2 * u], 1'b0)
        end
        test_done;
    end
endmodule
